// ===== include/defp_pkg.sv
// package for the dual encoder position follower
// assumes a single 40 MHz clock domain and synchronous reset
package defp_pkg;
  localparam int POS_W = 24;                  // position counter width
  localparam int ANG_W = 16;                  // angle settings width, in counts
  localparam int LAG_W = 16;                  // excess lag setting width
  localparam int LAG_MULT = 100;              // alarm threshold multiplier
  localparam int SYNC_STAGES = 3;             // pin synchroniser depth
  localparam logic [1:0] MODE_SPEED = 2'h0;   // speed following
  localparam logic [1:0] MODE_STANDBY = 2'h1; // standby index alignment
  localparam logic [1:0] MODE_SIMUL = 2'h2;   // simultaneous-start following
  localparam logic [POS_W-1:0] POS_ZERO = 24'h00_0000;

  // one encoder's raw pins
  typedef struct packed {
    logic phaseA;
    logic phaseB;
    logic index;
  } defp_enc_t;

  // follower state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_INDEX,
    ST_RUN,
    ST_MONITOR
  } defp_state_t;
endpackage

// ===== hw/defp_follower.sv
// dual encoder position follower: quadrature counting, deviation, lock and alarm
// assumes encoder pins are asynchronous; settings are static while running
`timescale 1ns/1ps
module defp_follower (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         srst,
  // encoder pins
  input  wire defp_pkg::defp_enc_t          refEnc,
  input  wire defp_pkg::defp_enc_t          folEnc,
  // control
  input  wire logic                         followerRun,
  input  wire logic                         protectTrip,
  input  wire logic                         singleMotorSel,
  // settings
  input  wire logic [1:0]                   followModeSelect,
  input  wire logic [defp_pkg::ANG_W-1:0]   indexAlignAngle,
  input  wire logic [defp_pkg::ANG_W-1:0]   lockDoneAngle,
  input  wire logic [defp_pkg::LAG_W-1:0]   excessLagLevel,
  // status
  output logic signed [defp_pkg::POS_W-1:0] deviation,
  output logic                              driveEnable,
  output logic                              lockAchievedFlag,
  output logic                              excessDevAlarm
);
  localparam int PW = defp_pkg::POS_W;

  // three-stage synchronisers; stage 1 only feeds stage 2
  logic [2:0] refS1Reg, refS2Reg, refS3Reg;
  logic [2:0] folS1Reg, folS2Reg, folS3Reg;
  logic [2:0] refStReg, folStReg; // debounced level: updates when stages 2 and 3 agree
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      refS1Reg <= 3'h0;
      refS2Reg <= 3'h0;
      refS3Reg <= 3'h0;
      folS1Reg <= 3'h0;
      folS2Reg <= 3'h0;
      folS3Reg <= 3'h0;
      refStReg <= 3'h0;
      folStReg <= 3'h0;
    end
    else
    begin
      refS1Reg <= {refEnc.index, refEnc.phaseB, refEnc.phaseA};
      refS2Reg <= refS1Reg;
      refS3Reg <= refS2Reg;
      folS1Reg <= {folEnc.index, folEnc.phaseB, folEnc.phaseA};
      folS2Reg <= folS1Reg;
      folS3Reg <= folS2Reg;
      for (int i = 0; i < 3; i++)
      begin
        if (refS2Reg[i] == refS3Reg[i])
          refStReg[i] <= refS3Reg[i];
        if (folS2Reg[i] == folS3Reg[i])
          folStReg[i] <= folS3Reg[i];
      end
    end
  end

  // quadrature decode: previous and new A/B state give direction
  logic [2:0] refPrevReg, folPrevReg;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      refPrevReg <= 3'h0;
      folPrevReg <= 3'h0;
    end
    else
    begin
      refPrevReg <= refStReg;
      folPrevReg <= folStReg;
    end
  end

  // a double step means pulses came faster than the sync can follow;
  // it is dropped rather than guessed, and the index correction repairs it
  function automatic logic signed [1:0] quadStep(input logic [1:0] prev, input logic [1:0] cur);
    logic [3:0] key;
    key = {prev, cur};
    case (key)
      4'h1, 4'h7, 4'hE, 4'h8: quadStep = 2'sb01;  // A leads B: up
      4'h2, 4'hB, 4'hD, 4'h4: quadStep = -2'sb01; // B leads A: down
      default:                quadStep = 2'sb00;  // no move or illegal double step
    endcase
  endfunction

  // B,A ordering: state = {B,A}; gray sequence 00->01->11->10 counts up
  wire logic signed [1:0] refStep  = quadStep({refPrevReg[1], refPrevReg[0]},
                                              {refStReg[1], refStReg[0]});
  wire logic signed [1:0] folStep  = quadStep({folPrevReg[1], folPrevReg[0]},
                                              {folStReg[1], folStReg[0]});
  wire logic              refIndex = refStReg[2] & ~refPrevReg[2];
  wire logic              folIndex = folStReg[2] & ~folPrevReg[2];

  // mode, cancel and control state
  wire logic cancelCond = ~followerRun | protectTrip | singleMotorSel;
  wire logic isStandby  = (followModeSelect == defp_pkg::MODE_STANDBY);
  wire logic isSimul    = (followModeSelect == defp_pkg::MODE_SIMUL);
  // simultaneous start keeps monitoring while the source stays dual and no protect trip is present
  wire logic keepCount  = isSimul & ~singleMotorSel & ~protectTrip;

  defp_pkg::defp_state_t stateReg, stateNext;
  logic signed [PW-1:0] refPosReg, refPosNext;
  logic signed [PW-1:0] folPosReg, folPosNext;
  logic                 refZSeenReg, folZSeenReg;
  logic signed [PW-1:0] refZPosReg, folZPosReg;  // position at last index
  logic signed [PW-1:0] zDiffReg;                // held index difference
  logic                 zDiffValidReg;
  logic                 alarmReg;

  wire logic signed [PW-1:0] alignOffset = PW'($signed({1'b0, indexAlignAngle}));
  wire logic signed [PW-1:0] devRaw      = refPosReg - folPosReg;

  // next state
  // standby has no revolution timer: the wait ends when both indexes arrive,
  // so a stalled encoder keeps the follower waiting with drive held off
  always_comb
  begin
    stateNext = stateReg;
    unique case (stateReg)
      defp_pkg::ST_IDLE:
        if (!cancelCond && !alarmReg)
          stateNext = isStandby ? defp_pkg::ST_WAIT_INDEX : defp_pkg::ST_RUN;
      defp_pkg::ST_WAIT_INDEX:
        if (cancelCond)
          stateNext = defp_pkg::ST_IDLE;
        else if (refZSeenReg && folZSeenReg)
          stateNext = defp_pkg::ST_RUN;
      defp_pkg::ST_RUN:
        if (cancelCond)
          stateNext = keepCount ? defp_pkg::ST_MONITOR : defp_pkg::ST_IDLE;
      defp_pkg::ST_MONITOR:
        if (!keepCount || !isSimul)
          stateNext = defp_pkg::ST_IDLE;
        else if (!cancelCond && !alarmReg)
          stateNext = defp_pkg::ST_RUN;
    endcase
  end

  // position accumulation with alignment and index correction
  wire logic starting  = (stateReg == defp_pkg::ST_IDLE) && (stateNext != defp_pkg::ST_IDLE);
  wire logic countOn   = (stateReg == defp_pkg::ST_RUN) || (stateReg == defp_pkg::ST_MONITOR);
  wire logic bothIndex = refIndex & folIndex;
  always_comb
  begin
    refPosNext = refPosReg;
    folPosNext = folPosReg;
    if (starting)
    begin
      // any start from idle: present phase becomes zero deviation
      refPosNext = defp_pkg::POS_ZERO;
      folPosNext = defp_pkg::POS_ZERO;
    end
    else if (stateReg == defp_pkg::ST_WAIT_INDEX)
    begin
      // follower waits; the alignment points define the zero
      refPosNext = refZSeenReg ? refPosReg + PW'(refStep) : defp_pkg::POS_ZERO;
      folPosNext = folZSeenReg ? folPosReg + PW'(folStep) : alignOffset;
    end
    else if (countOn)
    begin
      refPosNext = refPosReg + PW'(refStep);
      folPosNext = folPosReg + PW'(folStep);
      // coincident index: snap follower so deviation equals held index difference
      if (bothIndex && zDiffValidReg && (devRaw != zDiffReg))
        folPosNext = refPosReg + PW'(refStep) - zDiffReg;
    end
  end

  // state, positions, index tracking
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      stateReg      <= defp_pkg::ST_IDLE;
      refPosReg     <= defp_pkg::POS_ZERO;
      folPosReg     <= defp_pkg::POS_ZERO;
      refZSeenReg   <= 1'b0;
      folZSeenReg   <= 1'b0;
      refZPosReg    <= defp_pkg::POS_ZERO;
      folZPosReg    <= defp_pkg::POS_ZERO;
      zDiffReg      <= defp_pkg::POS_ZERO;
      zDiffValidReg <= 1'b0;
    end
    else
    begin
      stateReg  <= stateNext;
      refPosReg <= refPosNext;
      folPosReg <= folPosNext;
      if (starting)
      begin
        refZSeenReg <= 1'b0;
        folZSeenReg <= 1'b0;
        if (!(stateReg == defp_pkg::ST_IDLE && isSimul && zDiffValidReg))
          zDiffValidReg <= 1'b0;
      end
      else
      begin
        if (refIndex)
        begin
          refZSeenReg <= 1'b1;
          refZPosReg  <= refPosNext;
        end
        if (folIndex)
        begin
          folZSeenReg <= 1'b1;
          folZPosReg  <= folPosNext;
        end
        // record difference on the first coincident index pair while counting
        if (bothIndex && countOn && !zDiffValidReg)
        begin
          zDiffReg      <= refPosNext - folPosNext;
          zDiffValidReg <= 1'b1;
        end
      end
    end
  end

  // magnitude and thresholds
  // the threshold product stays inside the position width for any setting,
  // so no saturation is needed here
  wire logic signed [PW-1:0] devAbs   = devRaw[PW-1] ? -devRaw : devRaw;
  wire logic [PW-1:0]        lockThr  = PW'(lockDoneAngle);
  wire logic [PW-1:0]        lagThr   = PW'(excessLagLevel) * PW'(defp_pkg::LAG_MULT);
  wire logic                 isLocked = countOn && ($unsigned(devAbs) < lockThr);
  wire logic                 isExcess = countOn && ($unsigned(devAbs) > lagThr);

  // outputs; alarm latches until the follower run command drops with no trip
  // set wins over clear so an excess seen during release is never lost
  // drive uses the next state so it follows the state with no extra cycle
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      alarmReg         <= 1'b0;
      deviation        <= defp_pkg::POS_ZERO;
      driveEnable      <= 1'b0;
      lockAchievedFlag <= 1'b0;
      excessDevAlarm   <= 1'b0;
    end
    else
    begin
      if (isExcess)
        alarmReg <= 1'b1;
      else if (!followerRun && !protectTrip)
        alarmReg <= 1'b0;
      deviation        <= devRaw;
      driveEnable      <= (stateNext == defp_pkg::ST_RUN) && !isExcess && !alarmReg;
      lockAchievedFlag <= isLocked;
      excessDevAlarm   <= alarmReg | isExcess;
    end
  end
endmodule

// ===== tb/defp_enc_model.sv
// quadrature encoder model with index, pins change off the falling edge
// assumes the caller waits for each task to finish before the next
`timescale 1ns/1ps
module defp_enc_model (
  // clock
  input  wire logic           mclk,
  // encoder pins
  output defp_pkg::defp_enc_t enc
);
  int ph = 0;

  // step n counts; a 5-cycle level clears the 3-stage pin sync
  task automatic move(input int n);
    repeat (n < 0 ? -n : n)
    begin
      ph = (n < 0) ? (ph + 3) % 4 : (ph + 1) % 4;
      @(negedge mclk);
      enc.phaseA = (ph == 1) || (ph == 2);
      enc.phaseB = ph >= 2;
      repeat (4) @(negedge mclk);
    end
  endtask

  // one index event, wide enough to survive the sync
  task automatic pulse();
    @(negedge mclk);
    enc.index = 1'b1;
    repeat (6) @(negedge mclk);
    enc.index = 1'b0;
  endtask

  initial enc = '0;
endmodule

// ===== tb/defp_follower_chk.sv
// port-level checker for the position follower
// assumes settings stay static while following runs
`timescale 1ns/1ps
module defp_follower_chk (
  // clock and reset
  input wire logic                              mclk,
  input wire logic                              srst,
  // control
  input wire logic                              followerRun,
  input wire logic                              protectTrip,
  input wire logic                              singleMotorSel,
  // settings
  input wire logic [1:0]                        followModeSelect,
  input wire logic [defp_pkg::ANG_W-1:0]        lockDoneAngle,
  input wire logic [defp_pkg::LAG_W-1:0]        excessLagLevel,
  // status and pins
  input wire defp_pkg::defp_enc_t               refEnc,
  input wire defp_pkg::defp_enc_t               folEnc,
  input wire logic signed [defp_pkg::POS_W-1:0] deviation,
  input wire logic                              driveEnable,
  input wire logic                              lockAchievedFlag,
  input wire logic                              excessDevAlarm
);
  logic [23:0] absDev;
  logic [31:0] lagLimit;
  logic        runOk;
  // magnitude kept unsigned so the compares stay plain
  assign absDev = deviation[23] ? 24'(-deviation) : 24'(deviation);
  assign lagLimit = 32'(excessLagLevel) * 32'(defp_pkg::LAG_MULT);
  assign runOk = followerRun && !protectTrip && !singleMotorSel;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_lock;
    lockAchievedFlag && $stable(deviation) |-> absDev < 24'(lockDoneAngle);
  endproperty
  a_lock: assert property (p_lock) else $error("lock flag outside band");
  property p_cancel;
    driveEnable && !runOk |-> ##[1:2] !driveEnable;
  endproperty
  a_cancel: assert property (p_cancel) else $error("drive kept after cancel");
  property p_start;
    !driveEnable && runOk && !excessDevAlarm && followModeSelect != defp_pkg::MODE_STANDBY
      |-> ##[1:2] driveEnable;
  endproperty
  a_start: assert property (p_start) else $error("follow start missing");
  property p_stby;
    (followModeSelect == defp_pkg::MODE_STANDBY && !driveEnable && !refEnc.index
      && !folEnc.index) [*8] |=> !driveEnable;
  endproperty
  a_stby: assert property (p_stby) else $error("standby left without index");
  property p_run;
    driveEnable && runOk && !excessDevAlarm |=> driveEnable || excessDevAlarm;
  endproperty
  a_run: assert property (p_run) else $error("running follower dropped");
  property p_alm;
    excessDevAlarm |-> ##1 !driveEnable;
  endproperty
  a_alm: assert property (p_alm) else $error("drive on with alarm");
  property p_lim;
    $rose(excessDevAlarm) |-> absDev > lagLimit || $past(absDev) > lagLimit;
  endproperty
  a_lim: assert property (p_lim) else $error("alarm below limit");
  property p_zero;
    $rose(driveEnable) && followModeSelect == defp_pkg::MODE_SPEED |-> ##[0:1] deviation == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("deviation not zero at start");
endmodule

bind defp_follower defp_follower_chk u_chk (.mclk(mclk), .srst(srst),
  .followerRun(followerRun), .protectTrip(protectTrip), .singleMotorSel(singleMotorSel),
  .followModeSelect(followModeSelect), .lockDoneAngle(lockDoneAngle),
  .excessLagLevel(excessLagLevel), .refEnc(refEnc), .folEnc(folEnc), .deviation(deviation),
  .driveEnable(driveEnable), .lockAchievedFlag(lockAchievedFlag),
  .excessDevAlarm(excessDevAlarm));

// ===== tb/tb.sv
// self-checking bench for the position follower with two encoder models
// assumes 40 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
module tb;
  logic                mclk = 1'b0;
  logic                srst = 1'b1;
  defp_pkg::defp_enc_t refEnc;
  defp_pkg::defp_enc_t folEnc;
  logic                followerRun = 1'b0;
  logic                protectTrip = 1'b0;
  logic                singleMotorSel = 1'b0;
  logic [1:0]          followModeSelect = 2'h0;
  logic [15:0]         indexAlignAngle = 16'h0000;
  logic [15:0]         lockDoneAngle = 16'h0003;
  logic [15:0]         excessLagLevel = 16'h0001;
  logic signed [23:0]  deviation;
  logic                driveEnable;
  logic                lockAchievedFlag;
  logic                excessDevAlarm;
  int                  fails = 0;
  int                  cmp_count = 0;

  initial forever #12.5 mclk = ~mclk;

  // leading motor on the reference pins, driven motor on the follower pins
  defp_enc_model u_ref (.mclk(mclk), .enc(refEnc));
  defp_enc_model u_fol (.mclk(mclk), .enc(folEnc));
  defp_follower u_dut (.mclk(mclk), .srst(srst), .refEnc(refEnc), .folEnc(folEnc),
    .followerRun(followerRun), .protectTrip(protectTrip), .singleMotorSel(singleMotorSel),
    .followModeSelect(followModeSelect), .indexAlignAngle(indexAlignAngle),
    .lockDoneAngle(lockDoneAngle), .excessLagLevel(excessLagLevel), .deviation(deviation),
    .driveEnable(driveEnable), .lockAchievedFlag(lockAchievedFlag),
    .excessDevAlarm(excessDevAlarm));

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // a hang counts as a mismatch; 40000 cycles is far past the sequence
  initial
  begin
    #1_000_000;
    fails++;
    results();
  end

  initial
  begin
    w(12);
    srst = 1'b0;
    chk("drive", driveEnable, 0);
    // speed mode: start, count both ways, lock band edge
    followerRun = 1'b1;
    w(3);
    chk("drive", driveEnable, 1);
    u_ref.move(5);
    w(8);
    chk("dev", deviation, 24'h00_0005);
    chk("lock", lockAchievedFlag, 0);
    u_fol.move(3);
    w(8);
    chk("dev", deviation, 24'h00_0002);
    chk("lock", lockAchievedFlag, 1);
    u_ref.move(-2);
    w(8);
    chk("dev", deviation, 24'h00_0000);
    // trip cancels, clearing it restarts
    protectTrip = 1'b1;
    w(3);
    chk("drive", driveEnable, 0);
    protectTrip = 1'b0;
    w(3);
    chk("drive", driveEnable, 1);
    // alarm only once the limit of 100 counts is passed
    u_ref.move(100);
    w(8);
    chk("alarm", excessDevAlarm, 0);
    u_ref.move(1);
    w(8);
    chk("alarm", excessDevAlarm, 1);
    chk("drive", driveEnable, 0);
    followerRun = 1'b0;
    w(3);
    // standby: wait for both index events
    followModeSelect = defp_pkg::MODE_STANDBY;
    indexAlignAngle = 16'h0004;
    followerRun = 1'b1;
    w(20);
    chk("drive", driveEnable, 0);
    u_ref.pulse();
    w(10);
    chk("drive", driveEnable, 0);
    u_fol.pulse();
    w(10);
    chk("drive", driveEnable, 1);
    chk("dev", deviation, 24'hFF_FFFC);
    u_fol.move(2);
    w(8);
    chk("drive", driveEnable, 1);
    chk("dev", deviation, 24'hFF_FFFA);
    singleMotorSel = 1'b1;
    w(3);
    chk("drive", driveEnable, 0);
    singleMotorSel = 1'b0;
    followerRun = 1'b0;
    w(3);
    // simultaneous start: counting goes on after run removal
    followModeSelect = defp_pkg::MODE_SIMUL;
    followerRun = 1'b1;
    w(3);
    chk("dev", deviation, 24'h00_0000);
    u_ref.move(3);
    followerRun = 1'b0;
    w(3);
    chk("drive", driveEnable, 0);
    u_ref.move(2);
    w(8);
    chk("dev", deviation, 24'h00_0005);
    followerRun = 1'b1;
    w(3);
    chk("drive", driveEnable, 1);
    // coincident index pair stores the held difference, an extra follower count is then snapped back
    fork
      u_ref.pulse();
      u_fol.pulse();
    join
    w(10);
    u_fol.move(1);
    w(8);
    chk("dev", deviation, 24'h00_0004);
    fork
      u_ref.pulse();
      u_fol.pulse();
    join
    w(10);
    chk("dev", deviation, 24'h00_0005);
    results();
  end
endmodule
